//--- common/bpsc_pkg.sv
package bpsc_pkg;

	// ----------------------------------------
	// Pin states and selection codes
	// ----------------------------------------
	typedef enum logic [4:0] {
		BPSC_ST_RESET = 5'h01,
		BPSC_ST_HWSTBY = 5'h02,
		BPSC_ST_SWSTBY = 5'h04,
		BPSC_ST_RELEASE = 5'h08,
		BPSC_ST_RUN = 5'h10
	} bpsc_state_e;

	localparam logic [2:0] DRAS_NONE = 3'h0;
	localparam logic [2:0] DRAS_RS3_A = 3'h2;
	localparam logic [2:0] DRAS_RS4_A = 3'h4;
	localparam logic [2:0] DRAS_RS5 = 3'h5;
	localparam logic [2:0] DRAS_RS4_C = 3'h6;

	// Address bus goes low this many half cycles after reset is sampled
	localparam logic [2:0] ADDR_LOW_HALF_CYCLES = 3'h5;
	localparam logic [2:0] ADDR_LOW_DELAY = 3'h2;
	localparam logic [23:0] ADDR_RESET = 24'h000000;
	localparam logic [7:0] PORT_B_RESET = 8'h00;

	// One pin: output level and output enable
	typedef struct packed {
		logic level;
		logic drive;
	} bpsc_pin_s;

	// Chip configuration bits
	typedef struct packed {
		logic [2:0] dramAreaSelect;
		logic columnStrobePinChoice;
		logic chipSelect4Enable;
		logic chipSelect5Enable;
		logic chipSelect6Enable;
		logic chipSelect7Enable;
		logic standbyStrobeOutputEnable;
		logic expandedMode;
	} bpsc_cfg_s;

endpackage : bpsc_pkg

//--- hw/bpsc_pin_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Keep floats inputs, holds output levels
// - Address bit twenty: low in reset, standby enable
// - Row strobe five only at select 101
// - Else chip select five if enabled, else port
// - Row strobe four at 100, 101, 110
// - Else chip select four if enabled, else port
// - Row strobe three at 010, 100, 101
// - Column strobes when DRAM selected, choice zero
// - Chip selects seven, six when enabled
// - Reset: ports input, strobes high, data floats
// - Address low 2.5 cycles after reset sampled; code waits 3 cycles
// - Clock output on first edge in reset
// - Modes 3/4: address, selects float at reset; code drives address low at reset in every mode
module bpsc_pin_control (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire bpsc_pkg::bpsc_cfg_s cfg,
	input wire logic hwStandby,
	input wire logic swStandby,
	input wire logic busRelease,
	input wire logic [23:0] addressIn,
	input wire logic addressStrobeIn,
	input wire logic readStrobeIn,
	input wire logic upperWriteIn,
	input wire logic lowerWriteIn,
	input wire logic [7:0] chipSelectIn,
	input wire logic [5:3] rowStrobeIn,
	input wire logic upperColumnIn,
	input wire logic lowerColumnIn,
	input wire logic [7:0] portBOut,
	input wire logic [7:0] portBDir,
	input wire logic dataDrive,
	output bpsc_pkg::bpsc_state_e pinState,
	output logic [23:0] address,
	output logic addressDrive,
	output logic address_strobe_n,
	output logic read_strobe_n,
	output logic upper_write_strobe_n,
	output logic lower_write_strobe_n,
	output logic chip_select_zero,
	output logic dataBusDrive,
	output logic clockOutDrive,
	output logic port_a_bit_seven,
	output logic address_bit_twenty_drive,
	output logic [7:0] portBLevel,
	output logic [7:0] portBDrive,
	output logic row_strobe_three_select,
	output logic row_strobe_three,
	output logic row_strobe_three_drive
);
	// ----------------------------------------
	// State register
	// ----------------------------------------
	typedef struct packed {
		logic resetSeen;
		logic [23:0] addr;
	} bpsc_ctl_state_s;

	// Reset pin sequencer state, clocked even while the reset pin is low
	typedef struct packed {
		logic rstMeta;
		logic rstSync;
		logic [bpsc_pkg::ADDR_LOW_DELAY-1:0] lowHist;
		logic clkOut;
	} bpsc_seq_state_s;

	bpsc_ctl_state_s state;
	bpsc_ctl_state_s next_state;
	bpsc_seq_state_s seq;
	bpsc_seq_state_s next_seq;
	bpsc_pkg::bpsc_state_e mode;
	logic [7:0] wantLevel;
	logic [7:0] wantDrive;
	logic [7:0] isStrobe;
	logic [7:0] keepPin;
	logic [7:0] floatPin;
	logic dramAny;
	logic rs5Sel;
	logic rs4Sel;
	logic casSel;

	always_comb begin
		if (hwStandby) begin
			mode = bpsc_pkg::BPSC_ST_HWSTBY;
		end else if (!rst_n) begin
			mode = bpsc_pkg::BPSC_ST_RESET;
		end else if (swStandby) begin
			mode = bpsc_pkg::BPSC_ST_SWSTBY;
		end else if (busRelease) begin
			mode = bpsc_pkg::BPSC_ST_RELEASE;
		end else if (!state.resetSeen) begin
			mode = bpsc_pkg::BPSC_ST_RESET;
		end else begin
			mode = bpsc_pkg::BPSC_ST_RUN;
		end
	end
	assign pinState = mode;

	always_comb begin
		next_state = state;
		next_state.resetSeen = 1'b1;
		if (mode == bpsc_pkg::BPSC_ST_RUN) begin
			next_state.addr = addressIn;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Reset pin sequencer
	// ----------------------------------------
	// No reset here: it must count while the reset pin is held low
	always_comb begin
		next_seq.rstMeta = rst_n;
		next_seq.rstSync = seq.rstMeta;
		// Synchroniser plus history rounds the 2.5 cycles up, never early
		next_seq.lowHist = {seq.lowHist[bpsc_pkg::ADDR_LOW_DELAY-2:0], !seq.rstSync};
		next_seq.clkOut = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		seq <= next_seq;
	end

	// ----------------------------------------
	// Function selection
	// ----------------------------------------
	assign dramAny = cfg.dramAreaSelect != bpsc_pkg::DRAS_NONE;
	assign rs5Sel = cfg.dramAreaSelect == bpsc_pkg::DRAS_RS5;
	assign rs4Sel = cfg.dramAreaSelect == bpsc_pkg::DRAS_RS4_A || rs5Sel
		|| cfg.dramAreaSelect == bpsc_pkg::DRAS_RS4_C;
	assign row_strobe_three_select = cfg.dramAreaSelect == bpsc_pkg::DRAS_RS3_A
		|| cfg.dramAreaSelect == bpsc_pkg::DRAS_RS4_A || rs5Sel;
	assign casSel = dramAny && !cfg.columnStrobePinChoice;

	always_comb begin
		wantLevel = portBOut;
		wantDrive = portBDir;
		isStrobe = 8'h00;
		if (cfg.chipSelect6Enable) begin
			wantLevel[0] = chipSelectIn[6];
			isStrobe[0] = 1'b1;
		end
		if (cfg.chipSelect7Enable) begin
			wantLevel[1] = chipSelectIn[7];
			isStrobe[1] = 1'b1;
		end
		if (rs5Sel) begin
			wantLevel[2] = rowStrobeIn[5];
			isStrobe[2] = 1'b1;
		end else if (cfg.chipSelect5Enable) begin
			wantLevel[2] = chipSelectIn[5];
			isStrobe[2] = 1'b1;
		end
		if (rs4Sel) begin
			wantLevel[3] = rowStrobeIn[4];
			isStrobe[3] = 1'b1;
		end else if (cfg.chipSelect4Enable) begin
			wantLevel[3] = chipSelectIn[4];
			isStrobe[3] = 1'b1;
		end
		if (casSel) begin
			wantLevel[4] = lowerColumnIn;
			wantLevel[5] = upperColumnIn;
			isStrobe[5:4] = 2'h3;
		end
		wantDrive = wantDrive | isStrobe;
		keepPin = 8'h00;
		floatPin = 8'h00;
		case (mode)
			bpsc_pkg::BPSC_ST_RESET, bpsc_pkg::BPSC_ST_HWSTBY: begin
				floatPin = 8'hFF;
			end
			bpsc_pkg::BPSC_ST_SWSTBY: begin
				keepPin = ~isStrobe;
				if (cfg.standbyStrobeOutputEnable) begin
					wantLevel = wantLevel | isStrobe;
				end else begin
					floatPin = isStrobe;
				end
			end
			bpsc_pkg::BPSC_ST_RELEASE: begin
				keepPin = ~isStrobe;
				floatPin = isStrobe;
			end
			bpsc_pkg::BPSC_ST_RUN: begin
			end
			default: begin
				floatPin = 8'hFF;
			end
		endcase
	end

	// ----------------------------------------
	// Port B pins
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : gPin
			bpsc_pkg::bpsc_pin_s want;
			bpsc_pkg::bpsc_pin_s pin;
			assign want = '{level: wantLevel[i], drive: wantDrive[i]};
			bpsc_pin_keep uKeep (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.keep(keepPin[i]),
				.floatReq(floatPin[i]),
				.want(want),
				.pin(pin)
			);
			assign portBLevel[i] = pin.level;
			assign portBDrive[i] = pin.drive;
		end
	endgenerate

	// ----------------------------------------
	// Bus pins
	// ----------------------------------------
	always_comb begin
		address = state.addr;
		addressDrive = mode == bpsc_pkg::BPSC_ST_RUN;
		if (mode == bpsc_pkg::BPSC_ST_RESET) begin
			address = bpsc_pkg::ADDR_RESET;
			addressDrive = seq.lowHist[bpsc_pkg::ADDR_LOW_DELAY-1];
		end
		// Address bit twenty in expanded modes
		port_a_bit_seven = address[20];
		address_bit_twenty_drive = 1'b0;
		if (cfg.expandedMode) begin
			case (mode)
				bpsc_pkg::BPSC_ST_RESET: begin
					port_a_bit_seven = 1'b0;
					address_bit_twenty_drive = 1'b1;
				end
				bpsc_pkg::BPSC_ST_SWSTBY: begin
					port_a_bit_seven = state.addr[20];
					address_bit_twenty_drive = cfg.standbyStrobeOutputEnable;
				end
				bpsc_pkg::BPSC_ST_RUN: begin
					address_bit_twenty_drive = 1'b1;
				end
				default: begin
					address_bit_twenty_drive = 1'b0;
				end
			endcase
		end
	end

	wire logic running;
	assign running = rst_n && mode == bpsc_pkg::BPSC_ST_RUN;
	assign address_strobe_n = running ? addressStrobeIn : 1'b1;
	assign read_strobe_n = running ? readStrobeIn : 1'b1;
	assign upper_write_strobe_n = running ? upperWriteIn : 1'b1;
	assign lower_write_strobe_n = running ? lowerWriteIn : 1'b1;
	assign chip_select_zero = running ? chipSelectIn[0] : 1'b1;
	assign dataBusDrive = running && dataDrive;
	assign clockOutDrive = seq.clkOut && mode != bpsc_pkg::BPSC_ST_HWSTBY;
	assign row_strobe_three = mode == bpsc_pkg::BPSC_ST_SWSTBY ? 1'b1 : rowStrobeIn[3];
	assign row_strobe_three_drive = row_strobe_three_select && (running
		|| (mode == bpsc_pkg::BPSC_ST_SWSTBY && cfg.standbyStrobeOutputEnable));
endmodule : bpsc_pin_control

//--- hw/bpsc_pin_keep.sv
`timescale 1ns/1ps
// ----------------------------------------
// One pin with keep behaviour
// ----------------------------------------
module bpsc_pin_keep (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic keep,
	input wire logic floatReq,
	input wire bpsc_pkg::bpsc_pin_s want,
	output bpsc_pkg::bpsc_pin_s pin
);
	typedef struct packed {
		bpsc_pkg::bpsc_pin_s held;
	} bpsc_keep_state_s;

	bpsc_keep_state_s state;
	bpsc_keep_state_s next_state;

	always_comb begin
		next_state = state;
		if (floatReq) begin
			next_state.held.drive = 1'b0;
		end else if (!keep) begin
			next_state.held = want;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Keep: inputs stay floating, outputs hold last level
	assign pin = floatReq ? '{level: 1'b0, drive: 1'b0} : (keep ? state.held : want);
endmodule : bpsc_pin_keep

//--- verif/bpsc_ext_dev.sv
`timescale 1ns/1ps
// ----
// Far-side pull-ups on port B lines
// ----
module bpsc_ext_dev (
	input wire logic [7:0] portBLevel,
	input wire logic [7:0] portBDrive,
	output logic [7:0] pinB
);
	assign pinB = (portBDrive & portBLevel) | ~portBDrive;
endmodule : bpsc_ext_dev

//--- verif/bpsc_pin_control_sva.sv
`timescale 1ns/1ps
// ----
// Pin selection checks
// ----
module bpsc_pin_control_sva (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire bpsc_pkg::bpsc_cfg_s cfg,
	input wire bpsc_pkg::bpsc_state_e pinState,
	input wire logic [7:0] chipSelectIn,
	input wire logic [5:3] rowStrobeIn,
	input wire logic upperColumnIn,
	input wire logic lowerColumnIn,
	input wire logic [7:0] portBDir,
	input wire logic [7:0] portBLevel,
	input wire logic [7:0] portBDrive,
	input wire logic address_strobe_n,
	input wire logic chip_select_zero,
	input wire logic row_strobe_three_select,
	input wire logic row_strobe_three,
	input wire logic row_strobe_three_drive,
	input wire logic address_bit_twenty_drive,
	input wire logic clockOutDrive
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	logic run;
	logic sby;
	logic [2:0] das;
	assign run = pinState == bpsc_pkg::BPSC_ST_RUN;
	assign sby = pinState == bpsc_pkg::BPSC_ST_SWSTBY;
	assign das = cfg.dramAreaSelect;
	property p_rs5;
		run && das == 3'h5 |-> portBDrive[2] && portBLevel[2] == rowStrobeIn[5];
	endproperty
	a_rs5: assert property (p_rs5) else $error("row strobe five pin wrong");
	property p_cs5;
		run && das != 3'h5 |-> portBDrive[2] == (cfg.chipSelect5Enable || portBDir[2]);
	endproperty
	a_cs5: assert property (p_cs5) else $error("chip select five pin wrong");
	property p_rs4;
		run && das inside {3'h4, 3'h5, 3'h6} |-> portBLevel[3] == rowStrobeIn[4];
	endproperty
	a_rs4: assert property (p_rs4) else $error("row strobe four pin wrong");
	property p_rs3;
		run |-> row_strobe_three_select == (das inside {3'h2, 3'h4, 3'h5});
	endproperty
	a_rs3: assert property (p_rs3) else $error("row strobe three select wrong");
	property p_cas;
		run && das != 3'h0 && !cfg.columnStrobePinChoice
		|-> portBLevel[5:4] == {upperColumnIn, lowerColumnIn} && portBDrive[5:4] == 2'h3;
	endproperty
	a_cas: assert property (p_cas) else $error("column strobe pins wrong");
	property p_cs7;
		run && cfg.chipSelect7Enable |-> portBDrive[1] && portBLevel[1] == chipSelectIn[7];
	endproperty
	a_cs7: assert property (p_cs7) else $error("chip select seven pin wrong");
	property p_idle;
		!run |-> address_strobe_n && chip_select_zero;
	endproperty
	a_idle: assert property (p_idle) else $error("strobe low outside run");
	property p_sby;
		sby && cfg.chipSelect7Enable
		|-> portBDrive[1] == cfg.standbyStrobeOutputEnable && (portBLevel[1] || !portBDrive[1]);
	endproperty
	a_sby: assert property (p_sby) else $error("standby strobe pin wrong");
	property p_rs3sby;
		sby && row_strobe_three_select
		|-> row_strobe_three_drive == cfg.standbyStrobeOutputEnable && row_strobe_three;
	endproperty
	a_rs3sby: assert property (p_rs3sby) else $error("standby row strobe three wrong");
	property p_a20;
		sby && cfg.expandedMode |-> address_bit_twenty_drive == cfg.standbyStrobeOutputEnable;
	endproperty
	a_a20: assert property (p_a20) else $error("standby address bit twenty wrong");
	property p_clk;
		pinState != bpsc_pkg::BPSC_ST_HWSTBY |-> clockOutDrive;
	endproperty
	a_clk: assert property (p_clk) else $error("clock pin not driven");
endmodule : bpsc_pin_control_sva

bind bpsc_pin_control bpsc_pin_control_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg),
	.pinState(pinState), .chipSelectIn(chipSelectIn), .rowStrobeIn(rowStrobeIn),
	.upperColumnIn(upperColumnIn), .lowerColumnIn(lowerColumnIn), .portBDir(portBDir),
	.portBLevel(portBLevel), .portBDrive(portBDrive), .address_strobe_n(address_strobe_n),
	.chip_select_zero(chip_select_zero), .row_strobe_three_select(row_strobe_three_select),
	.row_strobe_three(row_strobe_three), .row_strobe_three_drive(row_strobe_three_drive),
	.address_bit_twenty_drive(address_bit_twenty_drive), .clockOutDrive(clockOutDrive));

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [9:0] c;
		logic sw;
		logic sel;
		logic [5:0] drv;
		logic [5:0] pin;
	} bpsc_row_s;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	bpsc_pkg::bpsc_cfg_s cfg = '0;
	logic swStandby = 1'b0;
	logic busRelease = 1'b0;
	logic [5:0] busIn = 6'h20;
	logic [7:0] csIn = 8'h50;
	logic [5:3] rsIn = 3'h2;
	logic [7:0] pDir = 8'h0F;
	logic [4:0] strb;
	logic [7:0] portBLevel;
	logic [7:0] portBDrive;
	logic [7:0] pinB;
	logic dataBusDrive;
	logic clockOutDrive;
	logic a20Drive;
	logic a20Level;
	logic [23:0] address;
	logic addressDrive;
	bpsc_pkg::bpsc_state_e pinState;
	logic rs3Sel;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	bpsc_row_s rows [7] = '{'{10'h280, 1'b0, 1'b1, 6'h3F, 6'h18},
		'{10'h03C, 1'b0, 1'b0, 6'h0F, 6'h39}, '{10'h340, 1'b0, 1'b0, 6'h0F, 6'h38},
		'{10'h210, 1'b0, 1'b1, 6'h3F, 6'h18}, '{10'h120, 1'b0, 1'b1, 6'h3F, 6'h18},
		'{10'h285, 1'b1, 1'b1, 6'h01, 6'h3E}, '{10'h287, 1'b1, 1'b1, 6'h3F, 6'h3E}};
	bpsc_pin_control u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .hwStandby(1'b0),
		.swStandby(swStandby), .busRelease(busRelease), .addressIn(24'h000000),
		.addressStrobeIn(busIn[0]), .readStrobeIn(busIn[1]), .upperWriteIn(busIn[2]),
		.lowerWriteIn(busIn[3]), .chipSelectIn(csIn), .rowStrobeIn(rsIn),
		.upperColumnIn(busIn[4]), .lowerColumnIn(~busIn[4]), .portBOut(8'h00),
		.portBDir(pDir), .dataDrive(busIn[5]), .pinState(pinState), .address(address),
		.addressDrive(addressDrive),
		.address_strobe_n(strb[4]), .read_strobe_n(strb[3]), .upper_write_strobe_n(strb[2]),
		.lower_write_strobe_n(strb[1]), .chip_select_zero(strb[0]),
		.dataBusDrive(dataBusDrive), .clockOutDrive(clockOutDrive), .port_a_bit_seven(a20Level),
		.address_bit_twenty_drive(a20Drive), .portBLevel(portBLevel), .portBDrive(portBDrive),
		.row_strobe_three_select(rs3Sel), .row_strobe_three(), .row_strobe_three_drive());
	bpsc_ext_dev u_ext (.portBLevel(portBLevel), .portBDrive(portBDrive), .pinB(pinB));
	always #50 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
		compares++;
		if (got !== ex) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, ex, got);
		end
	endtask : chk
	task automatic print_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 1000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		#10 rst_n = 1'b1;
		repeat (3) @(posedge sys_clk);
		foreach (rows[i]) begin
			#10;
			cfg = rows[i].c;
			swStandby = rows[i].sw;
			@(posedge sys_clk);
			#10;
			chk("drive", rows[i].drv, portBDrive[5:0]);
			chk("pins", rows[i].pin, pinB[5:0]);
			chk("rs3 select", rows[i].sel, rs3Sel);
			@(posedge sys_clk);
		end
		$display("test table done");
		#10;
		swStandby = 1'b0;
		busRelease = 1'b1;
		@(posedge sys_clk);
		#10 chk("release drive", 5'h00, portBDrive[5:1]);
		busRelease = 1'b0;
		cfg = 10'h285;
		$display("test release done");
		@(posedge sys_clk);
		#10 rst_n = 1'b0;
		#1;
		chk("strobes", 5'h1F, strb);
		chk("data and port drive", 9'h000, {dataBusDrive, portBDrive});
		chk("a20 drive", 1'b1, a20Drive);
		chk("a20 level", 1'b0, a20Level);
		chk("state", bpsc_pkg::BPSC_ST_RESET, pinState);
		chk("address early", 1'b0, addressDrive);
		repeat (2) @(posedge sys_clk);
		#10 chk("clock out", 1'b1, clockOutDrive);
		chk("address not yet", 1'b0, addressDrive);
		repeat (2) @(posedge sys_clk);
		#10 chk("address drive", 1'b1, addressDrive);
		chk("address low", 24'h000000, address);
		$display("test reset done");
		print_verdict();
	end
endmodule : testbench
